// file: pkg/tvu_pkg.sv
package tvu_pkg;
   // ----------------------------------------
   // Trap numbers and vectors
   // ----------------------------------------
   localparam logic [6:0] TRAP_NMI = 7'h02;
   localparam logic [6:0] TRAP_STACK_OVER = 7'h04;
   localparam logic [6:0] TRAP_STACK_UNDER = 7'h06;
   localparam logic [6:0] TRAP_CLASS_B = 7'h0A;
   localparam logic [6:0] TRAP_NODE_BASE = 7'h10;
   localparam logic [8:0] VEC_NMI = 9'h008;
   localparam logic [8:0] VEC_STACK_OVER = 9'h010;
   localparam logic [8:0] VEC_STACK_UNDER = 9'h018;
   localparam logic [8:0] VEC_CLASS_B = 9'h028;
   localparam int NODES = 16;
   localparam int FLAG_W = 8;
   // Trap flag bit positions
   localparam int FB_NMI = 7;
   localparam int FB_STACK_OVER = 6;
   localparam int FB_STACK_UNDER = 5;
   localparam int FB_UNDEF_OPCODE = 4;
   localparam int FB_PROT_FAULT = 3;
   localparam int FB_WORD_OPERAND = 2;
   localparam int FB_INSTR_ACCESS = 1;
   localparam int FB_EXT_BUS = 0;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [3:0] LEVEL_IDLE = 4'h0;
   // Service priorities; SVC_B and SVC_A rank above every interrupt level
   localparam logic [1:0] SVC_NONE = 2'h0;
   localparam logic [1:0] SVC_INT = 2'h1;
   localparam logic [1:0] SVC_B = 2'h2;
   localparam logic [1:0] SVC_A = 2'h3;

   function automatic logic [8:0] tvu_vec(input logic [6:0] num);
      tvu_vec = {num, 2'b00};
   endfunction : tvu_vec
endpackage : tvu_pkg

// file: rtl/tvu_trap_vector_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Hardware traps vector immediately, cannot be masked.
// - Each trap sets its own flag bit.
// - Trap preempts unless a trap of same or higher class active.
// - Interrupts and event transfers wait during traps.
// - Class A traps use their fixed vectors.
// - Class B causes share one vector, own flags.
// - Each node has request, enable, vector.
// - Trap instruction vectors to its number.
// - Sixteen levels; only higher priority preempts.
// - Software may set node request flag.
module tvu_trap_vector_unit
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] trap_event_in,
   input wire logic [7:0] trap_flag_clear_in,
   input wire logic [tvu_pkg::NODES-1:0] node_event_in,
   input wire logic [tvu_pkg::NODES-1:0] node_request_set_in,
   input wire logic [tvu_pkg::NODES-1:0] node_request_clear_in,
   input wire logic [tvu_pkg::NODES-1:0] node_enable_in,
   input wire logic [tvu_pkg::NODES*4-1:0] node_level_in,
   input wire logic [tvu_pkg::NODES-1:0] node_transfer_in,
   input wire logic sw_trap_in,
   input wire logic [6:0] sw_trap_num_in,
   input wire logic service_done_in,
   output logic branch_out,
   output logic [8:0] vector_out,
   output logic [6:0] trap_num_out,
   output logic transfer_req_out,
   output logic [3:0] transfer_node_out,
   output logic [7:0] trap_flag_register_out,
   output logic [tvu_pkg::NODES-1:0] node_request_flag_out,
   output logic [1:0] service_class_out,
   output logic [3:0] cpu_level_out
);
   import tvu_pkg::*;

   logic [7:0] flags_q, flags_d;
   logic [NODES-1:0] req_q, req_d;
   logic branch_q, branch_d, xfer_q, xfer_d;
   logic [8:0] vec_q, vec_d;
   logic [6:0] num_q, num_d;
   logic [3:0] pnode_q, pnode_d, lvl_q, lvl_d;
   logic [1:0] svc_q, svc_d;
   logic [7:0] trap_hit;
   logic class_a, class_b, best_v;
   logic [3:0] best_lvl, best_idx;

   // ----------------------------------------
   // Best pending enabled node
   // ----------------------------------------
   always_comb
   begin
      best_v = 1'b0;
      best_lvl = LEVEL_IDLE;
      best_idx = 4'h0;
      for (int i = 0; i < NODES; i++)
      begin
         if (req_q[i] && node_enable_in[i] && (!best_v || node_level_in[i*4 +: 4] > best_lvl))
         begin
            best_v = 1'b1;
            best_lvl = node_level_in[i*4 +: 4];
            best_idx = 4'(i);
         end
      end
   end

   // ----------------------------------------
   // Flags, arbitration and vectoring
   // ----------------------------------------
   always_comb
   begin
      trap_hit = trap_event_in;
      class_a = |trap_hit[FB_NMI:FB_STACK_UNDER];
      class_b = |trap_hit[FB_UNDEF_OPCODE:FB_EXT_BUS];
      flags_d = (flags_q & ~trap_flag_clear_in) | trap_hit;
      req_d = (req_q & ~node_request_clear_in) | node_event_in | node_request_set_in;
      branch_d = 1'b0;
      xfer_d = 1'b0;
      vec_d = vec_q;
      num_d = num_q;
      pnode_d = pnode_q;
      lvl_d = lvl_q;
      svc_d = svc_q;
      if (service_done_in)
      begin
         svc_d = SVC_NONE;
         lvl_d = LEVEL_IDLE;
      end
      if (class_a && svc_q != SVC_A)
      begin
         branch_d = 1'b1;
         svc_d = SVC_A;
         if (trap_hit[FB_NMI])
         begin
            vec_d = VEC_NMI;
            num_d = TRAP_NMI;
         end
         else if (trap_hit[FB_STACK_OVER])
         begin
            vec_d = VEC_STACK_OVER;
            num_d = TRAP_STACK_OVER;
         end
         else
         begin
            vec_d = VEC_STACK_UNDER;
            num_d = TRAP_STACK_UNDER;
         end
      end
      else if (class_b && svc_q < SVC_B)
      begin
         branch_d = 1'b1;
         svc_d = SVC_B;
         vec_d = VEC_CLASS_B;
         num_d = TRAP_CLASS_B;
      end
      else if (svc_q < SVC_B && sw_trap_in)
      begin
         branch_d = 1'b1;
         svc_d = SVC_INT;
         vec_d = tvu_vec(sw_trap_num_in);
         num_d = sw_trap_num_in;
      end
      else if (svc_q < SVC_B && best_v && (svc_q == SVC_NONE || best_lvl > lvl_q))
      begin
         req_d[best_idx] = 1'b0 | node_event_in[best_idx] | node_request_set_in[best_idx];
         if (node_transfer_in[best_idx])
         begin
            xfer_d = 1'b1;
            pnode_d = best_idx;
         end
         else
         begin
            branch_d = 1'b1;
            svc_d = SVC_INT;
            lvl_d = best_lvl;
            num_d = TRAP_NODE_BASE + 7'(best_idx);
            vec_d = tvu_vec(TRAP_NODE_BASE + 7'(best_idx));
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         flags_q <= FLAGS_RST;
         req_q <= '0;
         branch_q <= 1'b0;
         xfer_q <= 1'b0;
         vec_q <= '0;
         num_q <= '0;
         pnode_q <= '0;
         lvl_q <= LEVEL_IDLE;
         svc_q <= SVC_NONE;
      end
      else
      begin
         flags_q <= flags_d;
         req_q <= req_d;
         branch_q <= branch_d;
         xfer_q <= xfer_d;
         vec_q <= vec_d;
         num_q <= num_d;
         pnode_q <= pnode_d;
         lvl_q <= lvl_d;
         svc_q <= svc_d;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   assign branch_out = branch_q;
   assign vector_out = vec_q;
   assign trap_num_out = num_q;
   assign transfer_req_out = xfer_q;
   assign transfer_node_out = pnode_q;
   assign trap_flag_register_out = flags_q;
   assign node_request_flag_out = req_q;
   assign service_class_out = svc_q;
   assign cpu_level_out = lvl_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_nmi; trap_event_in[FB_NMI] && svc_q != SVC_A; endsequence
   sequence s_nmi_taken; branch_out && vector_out == 9'h008 && trap_num_out == 7'h02; endsequence

   nmi_vector_a: assert property (s_nmi |=> s_nmi_taken)
      else $error("nmi not vectored");
   trap_flag_set_a: assert property (trap_event_in[FB_EXT_BUS] |=> flags_q[FB_EXT_BUS])
      else $error("trap flag not set");
   class_b_vec_a: assert property (trap_event_in[FB_UNDEF_OPCODE] && svc_q == SVC_NONE
      && trap_event_in[FB_NMI:FB_STACK_UNDER] == 3'b000
      |=> vector_out == 9'h028 && trap_num_out == 7'h0A)
      else $error("class b vector wrong");
   stack_over_vec_a: assert property (trap_event_in[FB_STACK_OVER]
      && !trap_event_in[FB_NMI] && svc_q != SVC_A
      |=> vector_out == 9'h010 && trap_num_out == 7'h04)
      else $error("stack overflow vector wrong");
   trap_block_a: assert property (svc_q >= SVC_B && !service_done_in
      |=> !transfer_req_out)
      else $error("event transfer during trap");
   node_wait_a: assert property (svc_q >= SVC_B && !service_done_in
      |=> !branch_out || service_class_out >= SVC_B)
      else $error("interrupt during trap");
   vec_times4_a: assert property (branch_out |-> vector_out == {trap_num_out, 2'b00})
      else $error("vector not four times number");
   trap_nomask_a: assert property (class_a && svc_q != SVC_A |=> branch_out && svc_q == SVC_A)
      else $error("trap not taken");
   sw_trap_a: assert property (sw_trap_in && svc_q < SVC_B && trap_event_in == 8'h00
      |=> branch_out && trap_num_out == $past(sw_trap_num_in))
      else $error("software trap not vectored");
   sw_set_a: assert property (node_request_set_in[3]
      |=> node_request_flag_out[3] || $past(best_idx) == 4'h3)
      else $error("software request lost");
   level_rise_a: assert property (branch_out && svc_q == SVC_INT
      && $past(svc_q) == SVC_INT && !$past(service_done_in) && !$past(sw_trap_in)
      |-> cpu_level_out > $past(cpu_level_out))
      else $error("preempted by lower level");
endmodule : tvu_trap_vector_unit

// file: sim/tvu_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Core returning from service delay_in cycles after a branch seen while idle
// ----------------------------------------
module tvu_cpu_model
(
   input wire logic mclk_in,
   input wire logic branch_in,
   input wire logic [3:0] delay_in,
   output logic service_done_out
);
   initial
   begin
      service_done_out = 1'b0;
      forever
      begin
         @(negedge mclk_in iff branch_in === 1'b1);
         repeat (delay_in) @(posedge mclk_in);
         #1 service_done_out = 1'b1;
         @(posedge mclk_in);
         #1 service_done_out = 1'b0;
      end
   end
endmodule : tvu_cpu_model

// file: sim/trap_vector_unit_tb.sv
`timescale 1ns/1ps
module trap_vector_unit_tb;
   import tvu_pkg::*;
   logic mclk_in = 0, rst_n_in = 0, sw = 0, done, br, xfer;
   logic [7:0] ev = 0, clr = 0, flags;
   logic [NODES-1:0] nev = 0, nset = 0, nclr = 0, nen = 0, xon = 0, nreq;
   logic [NODES*4-1:0] lvl = 0;
   logic [6:0] swn = 0, num;
   logic [8:0] vec;
   logic [3:0] dly = 4'h2, pnode, clev;
   logic [1:0] cls;
   logic [15:0] q[$];
   logic [15:0] xq[$];
   int failures = 0, n_compared = 0, cyc = 0, a, b;
   always #10 mclk_in = ~mclk_in;
   tvu_trap_vector_unit dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .trap_event_in(ev),
      .trap_flag_clear_in(clr), .node_event_in(nev), .node_request_set_in(nset),
      .node_request_clear_in(nclr), .node_enable_in(nen), .node_level_in(lvl),
      .node_transfer_in(xon), .sw_trap_in(sw), .sw_trap_num_in(swn), .service_done_in(done),
      .branch_out(br), .vector_out(vec), .trap_num_out(num), .transfer_req_out(xfer),
      .transfer_node_out(pnode), .trap_flag_register_out(flags), .node_request_flag_out(nreq),
      .service_class_out(cls), .cpu_level_out(clev));
   tvu_cpu_model cpu (.mclk_in(mclk_in), .branch_in(br), .delay_in(dly), .service_done_out(done));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(string nm, logic [15:0] exp, logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task print_verdict;
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   task tick(int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : tick
   task expect_br(logic [6:0] n);
      q.push_back({n, n, 2'b00});
   endtask : expect_br
   task trap(int i, logic [6:0] n);
      expect_br(n);
      ev[i] = 1'b1;
      tick(1);
      ev = 8'h00;
      tick(3);
      chk("trap flags", 16'h0001 << i, flags);
      clr = 8'hFF;
      tick(1);
      clr = 8'h00;
      tick(8);
   endtask : trap
   // ----------------------------------------
   // Branch monitor and timeout
   // ----------------------------------------
   always @(negedge mclk_in)
   begin
      if (br === 1'b1)
         chk("branch", (q.size() > 0) ? q.pop_front() : 16'hFFFF, {num, vec});
      if (xfer === 1'b1)
         chk("transfer", (xq.size() > 0) ? xq.pop_front() : 16'hFFFF, 16'(pnode));
   end
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         failures++;
         print_verdict();
      end
   end
   initial
   begin
      a = $urandom(88806);
      for (a = 0; a < NODES; a++)
         lvl[4*a +: 4] = 4'($urandom) | 4'h1;
      tick(10);
      rst_n_in = 1'b1;
      tick(1);
      chk("reset flags", 16'h0000, flags);
      trap(FB_NMI, TRAP_NMI);
      trap(FB_STACK_OVER, TRAP_STACK_OVER);
      trap(FB_STACK_UNDER, TRAP_STACK_UNDER);
      for (a = 0; a < 5; a++)
         trap(a, TRAP_CLASS_B);
      repeat (4)
      begin
         swn = 7'($urandom);
         expect_br(swn);
         sw = 1'b1;
         tick(1);
         sw = 1'b0;
         tick(8);
      end
      nen = '1;
      for (b = 0; b < 2; b++)
         repeat (3)
         begin
            a = $urandom_range(NODES - 1);
            expect_br(7'(TRAP_NODE_BASE + a));
            if (b == 1) nset[a] = 1'b1;
            else nev[a] = 1'b1;
            tick(1);
            nset = '0;
            nev = '0;
            tick(8);
         end
      chk("node flags", 16'h0000, nreq);
      a = 3;
      b = 9;
      if (lvl[4*b +: 4] > lvl[4*a +: 4]) expect_br(7'(TRAP_NODE_BASE + b));
      expect_br(7'(TRAP_NODE_BASE + a));
      if (!(lvl[4*b +: 4] > lvl[4*a +: 4])) expect_br(7'(TRAP_NODE_BASE + b));
      nev[a] = 1'b1;
      nev[b] = 1'b1;
      tick(1);
      nev = '0;
      tick(16);
      dly = 4'hC;
      lvl[8 +: 4] = 4'h3;
      lvl[16 +: 4] = 4'h1;
      lvl[28 +: 4] = 4'h9;
      expect_br(7'(TRAP_NODE_BASE + 2));
      expect_br(7'(TRAP_NODE_BASE + 7));
      expect_br(7'(TRAP_NODE_BASE + 4));
      nev[2] = 1'b1;
      tick(1);
      nev = '0;
      tick(2);
      chk("level", 16'h0003, 16'(clev));
      nev[4] = 1'b1;
      nev[7] = 1'b1;
      tick(1);
      nev = '0;
      tick(3);
      chk("level", 16'h0009, 16'(clev));
      chk("low node waits", 16'h0001, 16'(nreq[4]));
      tick(24);
      xon[8] = 1'b1;
      expect_br(TRAP_CLASS_B);
      ev[FB_UNDEF_OPCODE] = 1'b1;
      tick(1);
      ev = 8'h00;
      nev[8] = 1'b1;
      tick(1);
      nev = '0;
      tick(11);
      chk("transfer held", 16'h0001, 16'(nreq[8]));
      xq.push_back(16'h0008);
      clr = 8'hFF;
      tick(1);
      clr = 8'h00;
      tick(4);
      chk("transfer served", 16'h0000, 16'(nreq[8]));
      expect_br(TRAP_NMI);
      expect_br(7'(TRAP_NODE_BASE + 5));
      ev[FB_NMI] = 1'b1;
      tick(1);
      ev = {3'b000, 1'b1, 4'h0};
      nev[5] = 1'b1;
      nen[6] = 1'b0;
      nev[6] = 1'b1;
      tick(1);
      ev = 8'h00;
      nev = '0;
      tick(3);
      chk("held flags", 16'h0090, flags);
      chk("class", 16'(SVC_A), cls);
      tick(24);
      chk("disabled node", 16'h0001, 16'(nreq[6]));
      chk("queue", 16'h0000, 16'(q.size()));
      chk("transfer queue", 16'h0000, 16'(xq.size()));
      print_verdict();
   end
endmodule : trap_vector_unit_tb
